// [hdl/acs_pkg.sv]
// Constants and types shared by the channel sequencer block.
// Contract
// - Config bits 0,0 give eight single-ended inputs referred to analog ground.
// - Config bit0=0, bit1=1 groups the inputs into four fully differential pairs.
// - Config 1,0 gives four pseudo differential pairs; 1,1 gives seven inputs.
// - In the seven-input setting each input is measured against input seven.
// - Differential span minus to plus reference maps onto codes 0 to 4095.
// - Both sequencing bits 0 convert the channel named by the pointer field.
// - Sequencing bits 0,1 cycle through the channels flagged in the list.
// - After loading the list the first conversion uses the lowest flagged channel.
// - Each later list conversion takes the next higher flagged channel.
// - After the highest flagged channel the list wraps to the lowest.
// - A write carrying pattern 1,0 during cycling leaves the cycling undisturbed.
// - Cycling runs until a write sets another pattern, which then takes effect.
// - Sequencing bits 1,1 convert channels 0 up to the pointer field.
// - Consecutive mode needs only the control write, no list write.
// - After enabling consecutive mode the next conversion is channel 0, then up.
// - After the last consecutive channel the run restarts from channel 0.
// - Trigger falling edge starts a conversion; busy stays high for its length.
package acs_pkg;

  // ---------------------------------------------------------------------------
  // Register map (byte addresses) and control and status field positions
  // ---------------------------------------------------------------------------
  localparam logic [3:0] ACS_CTRL_OFS   = 4'h0;
  localparam logic [3:0] ACS_LIST_OFS   = 4'h4;
  localparam logic [3:0] ACS_STATUS_OFS = 4'h8;
  localparam int         CTRL_PTR_LSB   = 0;
  localparam int         CTRL_AUTO_BIT  = 3;
  localparam int         CTRL_LIST_BIT  = 4;
  localparam int         CTRL_CFG0_BIT  = 5;
  localparam int         CTRL_CFG1_BIT  = 6;
  localparam int         STAT_CUR_LSB   = 0;
  localparam int         STAT_BUSY_BIT  = 3;
  localparam int         STAT_LAST_LSB  = 4;
  localparam int         STAT_RES_LSB   = 16;

  // ---------------------------------------------------------------------------
  // Reset values, encodings and timing
  // ---------------------------------------------------------------------------
  localparam logic [2:0]  PTR_RST      = 3'h0;
  localparam logic [7:0]  LIST_RST     = 8'h00;
  localparam logic [2:0]  CHAN_FIRST   = 3'h0;
  localparam logic [2:0]  CHAN_SHARED  = 3'h7;
  localparam logic [11:0] BIPOLAR_FLIP = 12'h800;
  localparam logic [31:0] RDATA_RST    = 32'h0000_0000;
  localparam int          CONV_TIME_NS = 600;
  localparam int          CLK_PERIOD_NS = 8;
  localparam int          CONV_CYCLES  =
    (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum {ACS_DIRECT, ACS_LIST, ACS_CONSEC} acs_mode_e;

endpackage

// [hdl/acs_sequencer.sv]
// Channel selection, input grouping and register slave of the converter.
`timescale 1ns/10ps
`default_nettype none

module acs_sequencer
  import acs_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        sample_trigger_n,
  input  wire logic [11:0] sar_code,
  output logic             busy,
  output logic      [2:0]  mux_pos,
  output logic      [2:0]  mux_neg,
  output logic             neg_to_ground,
  output logic      [11:0] result
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic        wait_q;
    logic [31:0] rdata_q;
    logic [2:0]  ptr_q;
    logic        auto_q;
    logic        list_en_q;
    logic        cfg0_q;
    logic        cfg1_q;
    logic [7:0]  list_q;
    logic [2:0]  cur_q;
    logic        busy_q;
    logic [6:0]  cnt_q;
    logic [2:0]  conv_q;
    logic [2:0]  pos_q;
    logic [2:0]  neg_q;
    logic        gnd_q;
    logic        bip_q;
    logic [11:0] res_q;
    logic        trg1_q;
    logic        trg2_q;
    logic        trg3_q;
  } acs_state_s;

  acs_state_s st_q;
  acs_state_s st_d;

  localparam logic [6:0] CONV_LAST = 7'(CONV_CYCLES - 1);

  // Lowest set bit of a mask, channel 0 when the mask is empty.
  function automatic logic [2:0] acs_lowest(input logic [7:0] m);
    logic [2:0] r;
    r = CHAN_FIRST;
    for (int i = 7; i >= 0; i--) begin
      if (m[i]) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction

  function automatic acs_mode_e acs_mode(input logic a, input logic l);
    acs_mode_e m;
    m = ACS_DIRECT;
    if (!a && l) begin
      m = ACS_LIST;
    end else if (a && l) begin
      m = ACS_CONSEC;
    end
    return m;
  endfunction

  // ---------------------------------------------------------------------------
  // Next flagged channel above the current one
  // ---------------------------------------------------------------------------
  logic [7:0] above_mask;

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_above
      assign above_mask[gi] = st_q.list_q[gi] && (3'(gi) > st_q.cur_q);
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------------
  acs_mode_e  mode;
  logic       acc;
  logic       wr_acc;
  logic       trig;
  logic       seq_run;
  logic       keep_pat;
  logic [2:0] ch;

  always_comb begin
    st_d     = st_q;
    mode     = acs_mode(st_q.auto_q, st_q.list_en_q);
    acc      = (avs_read || avs_write) && !st_q.wait_q;
    wr_acc   = acc && avs_write && avs_byteenable[0];
    trig     = !st_q.trg2_q && st_q.trg3_q && !st_q.busy_q;
    seq_run  = mode != ACS_DIRECT;
    keep_pat = avs_writedata[CTRL_AUTO_BIT] && !avs_writedata[CTRL_LIST_BIT];
    ch       = (mode == ACS_DIRECT) ? st_q.ptr_q : st_q.cur_q;

    // The trigger is a pin; only the second and third flops feed logic.
    // The flops reset high, so a pin held low across reset starts a conversion three cycles after reset.
    st_d.trg1_q = sample_trigger_n;
    st_d.trg2_q = st_q.trg1_q;
    st_d.trg3_q = st_q.trg2_q;

    // One wait cycle per request, then the answer for one cycle. Read data
    // is captured in the wait cycle so that it already stands at the edge
    // on which the master sees waitrequest low.
    st_d.wait_q = !((avs_read || avs_write) && st_q.wait_q);
    if (avs_read && st_q.wait_q) begin
      case (avs_address)
        ACS_CTRL_OFS: begin
          st_d.rdata_q = {25'h0, st_q.cfg1_q, st_q.cfg0_q, st_q.list_en_q,
                          st_q.auto_q, st_q.ptr_q};
        end
        ACS_LIST_OFS: begin
          st_d.rdata_q = {24'h0, st_q.list_q};
        end
        ACS_STATUS_OFS: begin
          st_d.rdata_q = {4'h0, st_q.res_q, 9'h0, st_q.conv_q,
                          st_q.busy_q, ch};
        end
        default: begin
          st_d.rdata_q = RDATA_RST;
        end
      endcase
    end

    // Conversion start: advance the pointer exactly once.
    if (trig) begin
      st_d.busy_q = 1'b1;
      st_d.cnt_q  = CONV_LAST;
      st_d.conv_q = ch;
      st_d.bip_q  = !st_q.cfg0_q && st_q.cfg1_q;
      case ({st_q.cfg1_q, st_q.cfg0_q})
        2'b00: begin
          st_d.pos_q = ch;
          st_d.neg_q = ch;
          st_d.gnd_q = 1'b1;
        end
        2'b11: begin
          st_d.pos_q = ch;
          st_d.neg_q = CHAN_SHARED;
          st_d.gnd_q = 1'b0;
        end
        default: begin
          st_d.pos_q = {ch[1:0], 1'b0};
          st_d.neg_q = {ch[1:0], 1'b1};
          st_d.gnd_q = 1'b0;
        end
      endcase
      case (mode)
        ACS_LIST: begin
          st_d.cur_q = (|above_mask) ? acs_lowest(above_mask)
                                     : acs_lowest(st_q.list_q);
        end
        ACS_CONSEC: begin
          st_d.cur_q = (st_q.cur_q == st_q.ptr_q) ? CHAN_FIRST
                                                  : st_q.cur_q + 3'h1;
        end
        default: begin
          st_d.cur_q = st_q.ptr_q;
        end
      endcase
    end else if (st_q.busy_q) begin
      st_d.cnt_q = st_q.cnt_q - 7'h1;
      if (st_q.cnt_q == 7'h0) begin
        st_d.busy_q = 1'b0;
        // Offset-binary in the fully differential grouping.
        st_d.res_q  = st_q.bip_q ? (sar_code ^ BIPOLAR_FLIP) : sar_code;
      end
    end

    // Register writes that reload the pointer override the pointer advance of the same cycle.
    if (wr_acc && avs_address == ACS_CTRL_OFS) begin
      st_d.cfg0_q = avs_writedata[CTRL_CFG0_BIT];
      st_d.cfg1_q = avs_writedata[CTRL_CFG1_BIT];
      if (!(seq_run && keep_pat)) begin
        st_d.auto_q    = avs_writedata[CTRL_AUTO_BIT];
        st_d.list_en_q = avs_writedata[CTRL_LIST_BIT];
        st_d.ptr_q     = avs_writedata[CTRL_PTR_LSB +: 3];
        case (acs_mode(avs_writedata[CTRL_AUTO_BIT],
                       avs_writedata[CTRL_LIST_BIT]))
          ACS_LIST: begin
            st_d.cur_q = acs_lowest(st_q.list_q);
          end
          ACS_CONSEC: begin
            st_d.cur_q = CHAN_FIRST;
          end
          default: begin
            st_d.cur_q = avs_writedata[CTRL_PTR_LSB +: 3];
          end
        endcase
      end
    end
    if (wr_acc && avs_address == ACS_LIST_OFS) begin
      st_d.list_q = avs_writedata[7:0];
      if (mode == ACS_LIST) begin
        st_d.cur_q = acs_lowest(avs_writedata[7:0]);
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      st_q           <= '0;
      st_q.wait_q    <= 1'b1;
      st_q.ptr_q     <= PTR_RST;
      st_q.list_q    <= LIST_RST;
      st_q.cur_q     <= CHAN_FIRST;
      st_q.gnd_q     <= 1'b1;
      st_q.trg1_q    <= 1'b1;
      st_q.trg2_q    <= 1'b1;
      st_q.trg3_q    <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign avs_readdata    = st_q.rdata_q;
  assign avs_waitrequest = st_q.wait_q;
  assign busy            = st_q.busy_q;
  assign mux_pos         = st_q.pos_q;
  assign mux_neg         = st_q.neg_q;
  assign neg_to_ground   = st_q.gnd_q;
  assign result          = st_q.res_q;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  localparam int CONV_LEN_A = CONV_CYCLES;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  sequence trig_seen;
    !st_q.trg2_q && st_q.trg3_q && !st_q.busy_q;
  endsequence
  sequence conv_begun;
    $rose(st_q.busy_q);
  endsequence
  // Triggers taken in a sequencing mode with no write in the same cycle;
  // a write there reloads the pointer and is checked on its own.
  sequence list_step;
    trig_seen and (!st_q.auto_q && st_q.list_en_q && !wr_acc);
  endsequence
  sequence consec_step;
    trig_seen and (st_q.auto_q && st_q.list_en_q && !wr_acc);
  endsequence

  busy_start_a: assert property (trig_seen |=> busy)
    else $error("busy did not rise after trigger edge");
  busy_len_a: assert property (
      conv_begun |-> ##(CONV_LEN_A) $fell(busy))
    else $error("busy length wrong");
  se_ground_a: assert property (conv_begun and
      $past(!st_q.cfg0_q && !st_q.cfg1_q)
      |-> neg_to_ground && mux_pos == st_q.conv_q)
    else $error("single-ended routing wrong");
  diff_pair_a: assert property (conv_begun and
      $past(!st_q.cfg0_q && st_q.cfg1_q)
      |-> !neg_to_ground && !mux_pos[0] && mux_neg == mux_pos + 3'h1)
    else $error("differential pairing wrong");
  shared_neg_a: assert property (conv_begun and
      $past(st_q.cfg0_q && st_q.cfg1_q)
      |-> mux_neg == CHAN_SHARED && !neg_to_ground)
    else $error("shared negative input not used");
  direct_sel_a: assert property (conv_begun and
      $past(!st_q.auto_q && !st_q.list_en_q)
      |-> st_q.conv_q == $past(st_q.ptr_q))
    else $error("direct channel not the pointer");
  list_flag_a: assert property (conv_begun and
      $past(st_q.list_en_q && !st_q.auto_q && (|st_q.list_q))
      |-> st_q.list_q[st_q.conv_q])
    else $error("list conversion on unflagged channel");
  consec_wrap_a: assert property (consec_step and
      (st_q.cur_q == st_q.ptr_q) |=> st_q.cur_q == CHAN_FIRST)
    else $error("consecutive run did not restart at channel 0");
  consec_load_a: assert property (wr_acc &&
      avs_address == ACS_CTRL_OFS && avs_writedata[CTRL_AUTO_BIT] &&
      avs_writedata[CTRL_LIST_BIT] |=> st_q.cur_q == CHAN_FIRST)
    else $error("consecutive mode did not start at channel 0");
  seq_keep_a: assert property (wr_acc && avs_address == ACS_CTRL_OFS &&
      keep_pat && st_q.list_en_q |=> $stable(st_q.list_en_q) &&
      $stable(st_q.auto_q) && $stable(st_q.ptr_q))
    else $error("cycling disturbed by keep pattern write");
  bus_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("wait cycle count wrong");

  // ---------------------------------------------------------------------------
  // Grouping, sequencing and result checks
  // ---------------------------------------------------------------------------
  pseudo_pair_a: assert property (conv_begun and
      $past(st_q.cfg0_q && !st_q.cfg1_q)
      |-> !neg_to_ground && !mux_pos[0] && mux_neg == mux_pos + 3'h1)
    else $error("pseudo differential pairing wrong");
  diff_code_a: assert property ($fell(busy) && $past(st_q.bip_q)
      |-> result == ($past(sar_code) ^ BIPOLAR_FLIP))
    else $error("differential result not offset binary");
  plain_code_a: assert property ($fell(busy) && !$past(st_q.bip_q)
      |-> result == $past(sar_code))
    else $error("result not the core code");
  busy_hold_a: assert property (busy && !st_q.trg2_q && st_q.trg3_q
      |=> $stable(st_q.conv_q) && $stable(mux_pos))
    else $error("trigger edge taken during a conversion");
  list_load_a: assert property (wr_acc && avs_address == ACS_LIST_OFS &&
      !st_q.auto_q && st_q.list_en_q && (|avs_writedata[7:0])
      |=> st_q.list_q[st_q.cur_q] &&
      (st_q.list_q & ((8'h01 << st_q.cur_q) - 8'h01)) == 8'h00)
    else $error("list load did not start at the lowest flag");
  list_next_a: assert property (list_step and (|above_mask)
      |=> st_q.cur_q > $past(st_q.cur_q) && st_q.list_q[st_q.cur_q] &&
      ($past(above_mask) & ((8'h01 << st_q.cur_q) - 8'h01)) == 8'h00)
    else $error("list did not step to the next flagged channel");
  list_wrap_a: assert property (list_step and
      (!(|above_mask) && (|st_q.list_q))
      |=> st_q.list_q[st_q.cur_q] &&
      (st_q.list_q & ((8'h01 << st_q.cur_q) - 8'h01)) == 8'h00)
    else $error("list did not wrap to the lowest flagged channel");
  consec_next_a: assert property (consec_step and
      (st_q.cur_q != st_q.ptr_q) |=> st_q.cur_q == $past(st_q.cur_q) + 3'h1)
    else $error("consecutive run did not step up by one");
  mode_set_a: assert property (wr_acc && avs_address == ACS_CTRL_OFS &&
      !keep_pat |=> st_q.auto_q == $past(avs_writedata[CTRL_AUTO_BIT]) &&
      st_q.list_en_q == $past(avs_writedata[CTRL_LIST_BIT]))
    else $error("sequencing bits not taken from a control write");
  ptr_once_a: assert property (
      !trig && !wr_acc |=> $stable(st_q.cur_q))
    else $error("channel pointer moved without a trigger");

endmodule

`default_nettype wire

// [sim/acs_core_model.sv]
// Behavioural model of the converter core feeding the sequencer.
`timescale 1ns/10ps
`default_nettype none

module acs_core_model (
  input  wire logic        busy,
  input  wire logic [2:0]  mux_pos,
  output logic      [11:0] sar_code
);
  // Outside a conversion the code is inverted, so a stale sample is seen.
  assign sar_code = busy ? {mux_pos, 9'h000} : ~{mux_pos, 9'h000};
endmodule

`default_nettype wire

// [sim/adc_channel_sequencer_test.sv]
// Self-checking testbench for the channel sequencer.
`timescale 1ns/10ps
`default_nettype none

module adc_channel_sequencer_test;
  import acs_pkg::*;
  logic        ref_clk = 1'b0;
  logic        nrst = 1'b0;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        trig_n = 1'b1;
  logic [11:0] sar_code;
  logic        busy;
  logic [2:0]  mux_pos;
  logic [2:0]  mux_neg;
  logic        neg_to_ground;
  logic [11:0] result;
  int          mismatches = 0;
  int          checked = 0;

  always #4 ref_clk = ~ref_clk;

  acs_sequencer acs_sequencer_inst (
    .ref_clk(ref_clk), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .sample_trigger_n(trig_n), .sar_code(sar_code), .busy(busy),
    .mux_pos(mux_pos), .mux_neg(mux_neg),
    .neg_to_ground(neg_to_ground), .result(result));

  acs_core_model acs_core_model_inst (
    .busy(busy), .mux_pos(mux_pos), .sar_code(sar_code));

  task automatic tally_and_finish;
    if (mismatches == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic hang(input string nm);
    mismatches++;
    $display("unexpected %s expected answer seen timeout", nm);
    tally_and_finish();
  endtask

  task automatic bus(input logic we, input logic [3:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    int n;
    @(posedge ref_clk);
    avs_read <= !we;
    avs_write <= we;
    avs_address <= a;
    avs_writedata <= wd;
    for (n = 0; n < 20; n++) begin
      @(posedge ref_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    if (n == 20) hang("waitrequest");
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic rd(input string nm, input logic [3:0] a,
                    input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    chk(nm, e, x);
  endtask

  // One conversion; the core echoes the positive channel in the top bits.
  task automatic conv(input logic [2:0] p, n, input logic g, fd);
    logic [11:0] r;
    int k;
    r = {p, 9'h000} ^ (fd ? 12'h800 : 12'h000);
    @(posedge ref_clk);
    trig_n <= 1'b0;
    for (k = 0; k < 10 && busy !== 1'b1; k++) @(posedge ref_clk);
    if (k == 10) hang("busy rise");
    chk("mux_pos", p, mux_pos);
    chk("neg_to_ground", g, neg_to_ground);
    if (!g) chk("mux_neg", n, mux_neg);
    trig_n <= 1'b1;
    for (k = 1; k < 100; k++) begin
      @(posedge ref_clk);
      if (busy !== 1'b1) break;
    end
    chk("busy cycles", CONV_CYCLES, k);
    chk("result", r, result);
  endtask

  // ---------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------
  task automatic reset_state;
    chk("neg_to_ground", 1'b1, neg_to_ground);
    chk("busy", 1'b0, busy);
    rd("status", ACS_STATUS_OFS, 32'h0);
    rd("unmapped", 4'hc, 32'h0);
  endtask

  task automatic groupings;
    wr(ACS_CTRL_OFS, 32'h05);
    conv(3'h5, 3'h0, 1'b1, 1'b0);
    wr(ACS_CTRL_OFS, 32'h42);
    conv(3'h4, 3'h5, 1'b0, 1'b1);
    wr(ACS_CTRL_OFS, 32'h21);
    conv(3'h2, 3'h3, 1'b0, 1'b0);
    wr(ACS_CTRL_OFS, 32'h63);
    conv(3'h3, 3'h7, 1'b0, 1'b0);
    rd("control", ACS_CTRL_OFS, 32'h63);
  endtask

  task automatic list_cycle;
    wr(ACS_CTRL_OFS, 32'h10);
    wr(ACS_LIST_OFS, 32'h94);
    conv(3'h2, 3'h0, 1'b1, 1'b0);
    conv(3'h4, 3'h0, 1'b1, 1'b0);
    wr(ACS_CTRL_OFS, 32'h0d);
    conv(3'h7, 3'h0, 1'b1, 1'b0);
    rd("status", ACS_STATUS_OFS, 32'h0e00_0072);
    conv(3'h2, 3'h0, 1'b1, 1'b0);
    wr(ACS_CTRL_OFS, 32'h05);
    conv(3'h5, 3'h0, 1'b1, 1'b0);
  endtask

  task automatic consecutive;
    wr(ACS_CTRL_OFS, 32'h1a);
    conv(3'h0, 3'h0, 1'b1, 1'b0);
    conv(3'h1, 3'h0, 1'b1, 1'b0);
    wr(ACS_CTRL_OFS, 32'h1a);
    conv(3'h0, 3'h0, 1'b1, 1'b0);
    conv(3'h1, 3'h0, 1'b1, 1'b0);
    conv(3'h2, 3'h0, 1'b1, 1'b0);
    conv(3'h0, 3'h0, 1'b1, 1'b0);
    rd("status", ACS_STATUS_OFS, 32'h0000_0001);
  endtask

  initial begin
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    reset_state();
    groupings();
    list_cycle();
    consecutive();
    tally_and_finish();
  end
endmodule

`default_nettype wire
